// ===== common/spfs_pkg.sv
// Constants for the serial port clock and frame sync block.
// Assumes APB register access with 32-bit aligned words.
package spfs_pkg;

  // Register byte addresses
  localparam logic [7:0] TX_CTL_ADDR  = 8'h00;
  localparam logic [7:0] RX_CTL_ADDR  = 8'h04;
  localparam logic [7:0] TX_DIV_ADDR  = 8'h08;
  localparam logic [7:0] RX_DIV_ADDR  = 8'h0c;
  localparam logic [7:0] TX_DATA_ADDR = 8'h10;
  localparam logic [7:0] RX_DATA_ADDR = 8'h14;
  localparam logic [7:0] STATUS_ADDR  = 8'h18;

  // Control register fields, same layout for both halves
  localparam int CTL_ENABLE   = 0;
  localparam int CTL_INT_CLK  = 1;
  localparam int CTL_EDGE     = 2;
  localparam int CTL_SYNC_REQ = 3;
  localparam int CTL_INT_SYNC = 4;
  localparam int CTL_POLARITY = 5;
  localparam int CTL_LATE     = 6;
  localparam int CTL_DATA_IND = 7;
  localparam int CTL_WLEN_LSB = 8;
  localparam int WLEN_W       = 5;
  localparam int CTL_FLAG     = 16;

  // Divisor register fields
  localparam int DIV_CLK_LSB  = 0;
  localparam int DIV_SYNC_LSB = 16;
  localparam int DIV_W        = 16;

  // Status register bits
  localparam int STAT_TX_FULL = 0;
  localparam int STAT_RX_FULL = 1;
  localparam int STAT_TX_BUSY = 2;
  localparam int STAT_RX_BUSY = 3;

  // Synchronised pin indices
  localparam int PIN_TX_CLK   = 0;
  localparam int PIN_RX_CLK   = 1;
  localparam int PIN_TX_SYNC  = 2;
  localparam int PIN_RX_SYNC  = 3;
  localparam int PIN_RX_DATA  = 4;
  localparam int PIN_COUNT    = 5;

  // Control write mask and reset values
  localparam logic [31:0] CTL_WMASK  = 32'h00001fff;
  localparam logic [31:0] CTL_RESET  = 32'h00001f00;
  localparam logic [31:0] DIV_RESET  = 32'h001f0003;
  localparam logic [31:0] DATA_RESET = 32'h00000000;

  typedef enum logic {
    SPFS_IDLE = 1'b0,
    SPFS_WORD = 1'b1
  } spfs_state_t;

endpackage

// ===== src/spfs_serial_port.sv
// Serial port with transmit and receive halves, clock and frame sync
// generation or capture, and an APB register file.
// Assumes serial pins are asynchronous to clk and much slower than it.
//
// Function
// - Word length field holds length minus one
// - Short words are right-aligned in buffers
// - Internal clock select drives clock from divisor
// - External clock taken from pin, clock divisor ignored
// - External serial clock crossed into system domain
// - Sync required means one sync per word
// - Without required sync, one sync starts stream
// - Internal sync select drives sync from divisor
// - External sync taken from pin, sync divisor ignored
// - Polarity bit selects active level, resets to 0 (active high)
// - Transmit drives on edge opposite selected edge
// - Receive captures on the selected edge
// - Early sync: data one cycle after sync
// - Early internal sync lasts one serial cycle
// - Late internal sync spans word, checked once
// - Data-dependent sync only with new word
// - Loaded word starts after next generated sync
// - Data-independent sync runs; stale resend flags
// - First independent sync waits for first write
`timescale 1ns/1ps
module spfs_serial_port (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        txClkIn,
  output logic             txClkOut,
  output logic             txClkOe,
  input  wire logic        txSyncIn,
  output logic             txSyncOut,
  output logic             txSyncOe,
  output logic             txDataOut,
  output logic             txDataOe,
  input  wire logic        rxClkIn,
  output logic             rxClkOut,
  output logic             rxClkOe,
  input  wire logic        rxSyncIn,
  output logic             rxSyncOut,
  output logic             rxSyncOe,
  input  wire logic        rxDataIn
);

  logic [31:0] txCtl;
  logic [31:0] rxCtl;
  logic [31:0] txDiv;
  logic [31:0] rxDiv;
  logic [31:0] txBuf;
  logic [31:0] rxBuf;
  logic        txBufFull;
  logic        rxBufFull;
  logic        txPrimed;
  logic        txUnderflow;
  logic        rxOverflow;
  logic [31:0] readMux;
  logic        mapped;
  logic        apbWrite;
  logic        apbRead;

  logic [spfs_pkg::PIN_COUNT-1:0] pinRaw;
  logic [spfs_pkg::PIN_COUNT-1:0] pinMeta;
  logic [spfs_pkg::PIN_COUNT-1:0] pinSync;

  logic [1:0]  halfEn;
  logic [1:0]  halfIntClk;
  logic [1:0]  halfIntSync;
  logic [1:0]  halfEdge;
  logic [1:0]  halfLate;
  logic [1:0]  halfPol;
  logic [4:0]  halfWl [2];
  logic [15:0] clkDiv [2];
  logic [15:0] syncDiv [2];
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [1:0]  sampleEv;
  logic [1:0]  driveEv;
  logic [1:0]  fire;
  logic [1:0]  fireOk;
  logic [1:0]  syncAct;
  logic [1:0]  syncPin;
  logic [1:0]  genClkV;

  spfs_pkg::spfs_state_t txState;
  spfs_pkg::spfs_state_t rxState;
  logic [31:0] txShift;
  logic [31:0] rxShift;
  logic [4:0]  txCnt;
  logic [4:0]  rxCnt;
  logic        txStarted;
  logic        rxStarted;
  logic        txArmed;
  logic        rxArmed;
  logic        txExtOk;
  logic        txFree;
  logic        txLoad;
  logic        txArmSet;
  logic        rxSyncSeen;
  logic        rxOk;
  logic        rxDeliver;
  logic [31:0] rxWord;

  assign halfEn      = {rxCtl[spfs_pkg::CTL_ENABLE],
                        txCtl[spfs_pkg::CTL_ENABLE]};
  assign halfIntClk  = {rxCtl[spfs_pkg::CTL_INT_CLK],
                        txCtl[spfs_pkg::CTL_INT_CLK]};
  assign halfIntSync = {rxCtl[spfs_pkg::CTL_INT_SYNC],
                        txCtl[spfs_pkg::CTL_INT_SYNC]};
  assign halfEdge    = {rxCtl[spfs_pkg::CTL_EDGE], txCtl[spfs_pkg::CTL_EDGE]};
  assign halfLate    = {rxCtl[spfs_pkg::CTL_LATE], txCtl[spfs_pkg::CTL_LATE]};
  assign halfPol     = {rxCtl[spfs_pkg::CTL_POLARITY],
                        txCtl[spfs_pkg::CTL_POLARITY]};
  assign halfWl[0]   = txCtl[spfs_pkg::CTL_WLEN_LSB +: spfs_pkg::WLEN_W];
  assign halfWl[1]   = rxCtl[spfs_pkg::CTL_WLEN_LSB +: spfs_pkg::WLEN_W];
  assign clkDiv[0]   = txDiv[spfs_pkg::DIV_CLK_LSB +: spfs_pkg::DIV_W];
  assign clkDiv[1]   = rxDiv[spfs_pkg::DIV_CLK_LSB +: spfs_pkg::DIV_W];
  assign syncDiv[0]  = txDiv[spfs_pkg::DIV_SYNC_LSB +: spfs_pkg::DIV_W];
  assign syncDiv[1]  = rxDiv[spfs_pkg::DIV_SYNC_LSB +: spfs_pkg::DIV_W];

  // Data-dependent transmit sync needs a fresh word; independent mode
  // only waits for the very first write
  assign fireOk[0] = txCtl[spfs_pkg::CTL_DATA_IND] ? txPrimed
                                                   : txBufFull;
  assign fireOk[1] = 1'b1;

  // Pins are asynchronous; two flops before anything looks at them
  assign pinRaw = {rxDataIn, rxSyncIn, txSyncIn, rxClkIn, txClkIn};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pinMeta <= '0;
      pinSync <= '0;
    end
    else
    begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_half
    logic [15:0] divCnt;
    logic        genClk;
    logic        extPrev;
    logic [15:0] fsCnt;
    logic [4:0]  holdCnt;
    logic        act;
    logic        pinLevel;

    // Serial clock period is two times (divisor plus one) system clocks
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        divCnt <= '0;
        genClk <= 1'b0;
      end
      else if (!halfEn[g] || !halfIntClk[g])
      begin
        divCnt <= '0;
        genClk <= 1'b0;
      end
      else if (divCnt == 16'h0000)
      begin
        divCnt <= clkDiv[g];
        genClk <= ~genClk;
      end
      else
      begin
        divCnt <= divCnt - 16'h0001;
      end
    end

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        extPrev <= 1'b0;
      else
        extPrev <= pinSync[g];
    end

    assign rise[g] = halfIntClk[g]
      ? (halfEn[g] && divCnt == 16'h0000 && !genClk)
      : (halfEn[g] && pinSync[g] && !extPrev);
    assign fall[g] = halfIntClk[g]
      ? (halfEn[g] && divCnt == 16'h0000 && genClk)
      : (halfEn[g] && !pinSync[g] && extPrev);
    assign sampleEv[g] = halfEdge[g] ? rise[g] : fall[g];
    assign driveEv[g]  = halfEdge[g] ? fall[g] : rise[g];
    assign fire[g] = driveEv[g] && halfIntSync[g] && fsCnt == 16'h0000
                     && fireOk[g];
    assign genClkV[g] = genClk;
    assign syncAct[g] = act;
    assign syncPin[g] = pinLevel;

    // Sync interval is divisor plus one serial clocks
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        fsCnt <= '0;
      else if (!halfEn[g] || !halfIntSync[g] || !fireOk[g])
        fsCnt <= '0;
      else if (driveEv[g])
        fsCnt <= (fsCnt == 16'h0000) ? syncDiv[g]
                                     : fsCnt - 16'h0001;
    end

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        act     <= 1'b0;
        holdCnt <= '0;
      end
      else if (!halfEn[g] || !halfIntSync[g])
      begin
        act     <= 1'b0;
        holdCnt <= '0;
      end
      else if (driveEv[g])
      begin
        if (fire[g])
        begin
          act     <= 1'b1;
          holdCnt <= halfLate[g] ? halfWl[g] : 5'h00;
        end
        else if (holdCnt != 5'h00)
          holdCnt <= holdCnt - 5'h01;
        else
          act <= 1'b0;
      end
    end

    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
        pinLevel <= 1'b0;
      else
        pinLevel <= act ^ halfPol[g];
    end
  end

  assign txClkOut  = genClkV[0];
  assign rxClkOut  = genClkV[1];
  assign txClkOe   = halfEn[0] && halfIntClk[0];
  assign rxClkOe   = halfEn[1] && halfIntClk[1];
  assign txSyncOut = syncPin[0];
  assign rxSyncOut = syncPin[1];
  assign txSyncOe  = halfEn[0] && halfIntSync[0];
  assign rxSyncOe  = halfEn[1] && halfIntSync[1];
  assign txDataOe  = halfEn[0];

  // Transmit framing; sync is only looked at on a word boundary
  assign txExtOk = !halfIntSync[0] && (pinSync[spfs_pkg::PIN_TX_SYNC]
                   ^ halfPol[0]) && (!txStarted
                   || txCtl[spfs_pkg::CTL_SYNC_REQ]);
  assign txFree  = (txState == spfs_pkg::SPFS_IDLE) || (txCnt == 5'h00);
  assign txLoad  = halfEn[0] && (
      (driveEv[0] && txFree && (txArmed
        || (txStarted && !txCtl[spfs_pkg::CTL_SYNC_REQ]
            && txState == spfs_pkg::SPFS_WORD)
        || (fire[0] && halfLate[0])))
      || (sampleEv[0] && halfLate[0] && txExtOk
          && txState == spfs_pkg::SPFS_IDLE));
  assign txArmSet = (fire[0] && !halfLate[0])
      || (sampleEv[0] && !halfLate[0] && txExtOk && txFree);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      txState   <= spfs_pkg::SPFS_IDLE;
      txShift   <= spfs_pkg::DATA_RESET;
      txCnt     <= '0;
      txDataOut <= 1'b0;
      txStarted <= 1'b0;
      txArmed   <= 1'b0;
    end
    else if (!halfEn[0])
    begin
      txState   <= spfs_pkg::SPFS_IDLE;
      txCnt     <= '0;
      txDataOut <= 1'b0;
      txStarted <= 1'b0;
      txArmed   <= 1'b0;
    end
    else
    begin
      if (txLoad)
      begin
        txState   <= spfs_pkg::SPFS_WORD;
        txShift   <= txBuf;
        txDataOut <= txBuf[halfWl[0]];
        txCnt     <= halfWl[0];
        txStarted <= 1'b1;
      end
      else if (driveEv[0] && txState == spfs_pkg::SPFS_WORD)
      begin
        if (txCnt == 5'h00)
          txState <= spfs_pkg::SPFS_IDLE;
        else
        begin
          txShift   <= txShift << 1;
          txDataOut <= txShift[halfWl[0] - 5'h01];
          txCnt     <= txCnt - 5'h01;
        end
      end
      if (txLoad)
        txArmed <= 1'b0;
      else if (txArmSet)
        txArmed <= 1'b1;
    end
  end

  // Receive framing
  assign rxSyncSeen = halfIntSync[1] ? syncAct[1]
                    : (pinSync[spfs_pkg::PIN_RX_SYNC] ^ halfPol[1]);
  assign rxOk = rxSyncSeen && (!rxStarted
                || rxCtl[spfs_pkg::CTL_SYNC_REQ]);
  assign rxDeliver = sampleEv[1] && rxState == spfs_pkg::SPFS_WORD
                     && rxCnt == 5'h01;
  assign rxWord = {rxShift[30:0], pinSync[spfs_pkg::PIN_RX_DATA]};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rxState   <= spfs_pkg::SPFS_IDLE;
      rxShift   <= spfs_pkg::DATA_RESET;
      rxCnt     <= '0;
      rxStarted <= 1'b0;
      rxArmed   <= 1'b0;
    end
    else if (!halfEn[1])
    begin
      rxState   <= spfs_pkg::SPFS_IDLE;
      rxCnt     <= '0;
      rxStarted <= 1'b0;
      rxArmed   <= 1'b0;
    end
    else if (sampleEv[1])
    begin
      if (rxState == spfs_pkg::SPFS_WORD)
      begin
        rxShift <= rxWord;
        rxCnt   <= rxCnt - 5'h01;
        if (rxCnt == 5'h01)
        begin
          rxState <= spfs_pkg::SPFS_IDLE;
          rxArmed <= (rxStarted && !rxCtl[spfs_pkg::CTL_SYNC_REQ])
                     || (!halfLate[1] && rxOk);
        end
      end
      else if (rxArmed || (halfLate[1] && rxOk))
      begin
        // Clearing upper bits keeps short words right-aligned
        rxShift   <= {31'h00000000, pinSync[spfs_pkg::PIN_RX_DATA]};
        rxCnt     <= halfWl[1];
        rxState   <= spfs_pkg::SPFS_WORD;
        rxArmed   <= 1'b0;
        rxStarted <= 1'b1;
      end
      else if (rxOk)
      begin
        rxArmed   <= 1'b1;
        rxStarted <= 1'b1;
      end
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb
  begin
    readMux = '0;
    mapped  = 1'b1;
    if (paddr == spfs_pkg::TX_CTL_ADDR)
    begin
      readMux = txCtl;
      readMux[spfs_pkg::CTL_FLAG] = txUnderflow;
    end
    else if (paddr == spfs_pkg::RX_CTL_ADDR)
    begin
      readMux = rxCtl;
      readMux[spfs_pkg::CTL_FLAG] = rxOverflow;
    end
    else if (paddr == spfs_pkg::TX_DIV_ADDR)
      readMux = txDiv;
    else if (paddr == spfs_pkg::RX_DIV_ADDR)
      readMux = rxDiv;
    else if (paddr == spfs_pkg::TX_DATA_ADDR)
      readMux = txBuf;
    else if (paddr == spfs_pkg::RX_DATA_ADDR)
      readMux = rxBuf;
    else if (paddr == spfs_pkg::STATUS_ADDR)
    begin
      readMux[spfs_pkg::STAT_TX_FULL] = txBufFull;
      readMux[spfs_pkg::STAT_RX_FULL] = rxBufFull;
      readMux[spfs_pkg::STAT_TX_BUSY] = txState == spfs_pkg::SPFS_WORD;
      readMux[spfs_pkg::STAT_RX_BUSY] = rxState == spfs_pkg::SPFS_WORD;
    end
    else
      mapped = 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= readMux;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      txCtl <= spfs_pkg::CTL_RESET;
      rxCtl <= spfs_pkg::CTL_RESET;
      txDiv <= spfs_pkg::DIV_RESET;
      rxDiv <= spfs_pkg::DIV_RESET;
    end
    else if (apbWrite)
    begin
      if (paddr == spfs_pkg::TX_CTL_ADDR)
        txCtl <= pwdata & spfs_pkg::CTL_WMASK;
      else if (paddr == spfs_pkg::RX_CTL_ADDR)
        rxCtl <= pwdata & spfs_pkg::CTL_WMASK;
      else if (paddr == spfs_pkg::TX_DIV_ADDR)
        txDiv <= pwdata;
      else if (paddr == spfs_pkg::RX_DIV_ADDR)
        rxDiv <= pwdata;
    end
  end

  // Transmit buffer; a write in the load cycle keeps the buffer full
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      txBuf       <= spfs_pkg::DATA_RESET;
      txBufFull   <= 1'b0;
      txPrimed    <= 1'b0;
      txUnderflow <= 1'b0;
    end
    else
    begin
      if (txLoad)
        txBufFull <= 1'b0;
      if (apbWrite && paddr == spfs_pkg::TX_DATA_ADDR)
      begin
        txBuf     <= pwdata;
        txBufFull <= 1'b1;
      end
      if (!halfEn[0])
        txPrimed <= 1'b0;
      else if (apbWrite && paddr == spfs_pkg::TX_DATA_ADDR)
        txPrimed <= 1'b1;
      if (apbWrite && paddr == spfs_pkg::TX_CTL_ADDR
          && pwdata[spfs_pkg::CTL_FLAG])
        txUnderflow <= 1'b0;
      if (txLoad && !txBufFull)
        txUnderflow <= 1'b1;
    end
  end

  // Receive buffer; a delivery in the read cycle keeps it full
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rxBuf      <= spfs_pkg::DATA_RESET;
      rxBufFull  <= 1'b0;
      rxOverflow <= 1'b0;
    end
    else
    begin
      if (apbRead && paddr == spfs_pkg::RX_DATA_ADDR)
        rxBufFull <= 1'b0;
      if (apbWrite && paddr == spfs_pkg::RX_CTL_ADDR
          && pwdata[spfs_pkg::CTL_FLAG])
        rxOverflow <= 1'b0;
      if (rxDeliver)
      begin
        rxBuf     <= rxWord;
        rxBufFull <= 1'b1;
        if (rxBufFull && !(apbRead && paddr == spfs_pkg::RX_DATA_ADDR))
          rxOverflow <= 1'b1;
      end
    end
  end

endmodule // spfs_serial_port

// ===== tb/spfs_far_side.sv
// Far-side codec model: drives the receive pins and captures transmit.
// Assumes edge select 1 at both ends and active-high syncs.
`timescale 1ns/1ps
module spfs_far_side (
  output logic       rxClkIn = 1'h0,
  output logic       rxSyncIn = 1'h0,
  output logic       rxDataIn = 1'h0,
  input  wire logic  txClkOut,
  input  wire logic  txSyncOut,
  input  wire logic  txDataOut
);
  logic        late = 1'h0;
  logic        done = 1'h0;
  logic        busy = 1'h0;
  int          len = 8;
  int          n = 0;
  int          syncs = 0;
  logic [31:0] word = 32'h0;

  // Clock stands still between frames; data left at inverse of last bit
  task automatic send(input logic [31:0] w, input int bits);
    #5 rxSyncIn = 1'h1;
    #100 rxClkIn = 1'h1;
    #100 rxClkIn = 1'h0;
    rxSyncIn = 1'h0;
    for (int i = bits - 1; i >= 0; i--)
    begin
      rxDataIn = w[i];
      #100 rxClkIn = 1'h1;
      #100 rxClkIn = 1'h0;
    end
    rxDataIn = ~rxDataIn;
  endtask

  // Samples on the rising edge, the one the device does not drive on
  always @(posedge txClkOut)
    if (busy)
    begin
      word = {word[30:0], txDataOut};
      n = n + 1;
      if (n == len)
      begin
        busy = 1'h0;
        done = 1'h1;
      end
    end
    else if (txSyncOut === 1'h1)
    begin
      syncs = syncs + 1;
      busy = 1'h1;
      word = late ? {31'h0, txDataOut} : 32'h0;
      n = late ? 1 : 0;
    end
endmodule // spfs_far_side

// ===== tb/spfs_properties.sv
// Checker on the serial port pins and APB answer.
// Assumes register writes land on the APB access edge.
`timescale 1ns/1ps
module spfs_properties (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        txClkOut,
  input wire logic        txClkOe,
  input wire logic        txSyncOut,
  input wire logic        txSyncOe,
  input wire logic        txDataOut,
  input wire logic        rxClkOe,
  input wire logic        rxSyncOe
);
  logic [31:0] txCtl;
  logic [31:0] rxCtl;
  logic [31:0] txDiv;
  logic [15:0] hold;
  logic [15:0] syncLen;
  logic [15:0] syncExp;
  logic        lastClk;
  logic        steady;
  logic        txIc;
  logic        txIs;
  logic        act;
  logic        mapped;

  assign txIc = txCtl[0] & txCtl[1];
  assign txIs = txIc & txCtl[4];
  assign act = txSyncOut ^ txCtl[5];
  assign syncExp = 16'(2 * (txDiv[15:0] + 1)
    * (txCtl[6] ? txCtl[12:8] + 1 : 1));
  assign mapped = paddr[1:0] == 2'h0 && paddr <= spfs_pkg::STATUS_ADDR;

  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      txCtl <= spfs_pkg::CTL_RESET;
      rxCtl <= spfs_pkg::CTL_RESET;
      txDiv <= spfs_pkg::DIV_RESET;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == spfs_pkg::TX_CTL_ADDR)
        txCtl <= pwdata & spfs_pkg::CTL_WMASK;
      if (paddr == spfs_pkg::RX_CTL_ADDR)
        rxCtl <= pwdata & spfs_pkg::CTL_WMASK;
      if (paddr == spfs_pkg::TX_DIV_ADDR)
        txDiv <= pwdata;
    end

  // First toggle after enable has no reference, so it is not judged
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      hold <= 16'h0;
      lastClk <= 1'h0;
      steady <= 1'h0;
    end
    else
    begin
      lastClk <= txClkOut;
      hold <= (txClkOut != lastClk) ? 16'h1 : hold + 16'h1;
      steady <= txIc & (steady | (txClkOut != lastClk));
    end

  always_ff @(posedge clk or posedge reset)
    if (reset)
      syncLen <= 16'h0;
    else
      syncLen <= act ? syncLen + 16'h1 : 16'h0;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_tx_clk_oe:
    assert property (txClkOe == txIc) else $error("tx clock enable wrong");
  a_tx_sync_oe:
    assert property (txSyncOe == (txCtl[0] & txCtl[4]))
    else $error("tx sync enable wrong");
  a_rx_clk_oe:
    assert property (rxClkOe == (rxCtl[0] & rxCtl[1]))
    else $error("rx clock enable wrong");
  a_rx_sync_oe:
    assert property (rxSyncOe == (rxCtl[0] & rxCtl[4]))
    else $error("rx sync enable wrong");
  a_clk_half_period:
    assert property (txClkOut != lastClk && steady && txIc
      |-> hold == txDiv[15:0] + 16'h1) else $error("tx clock period wrong");
  a_sync_length:
    assert property (txIs && $fell(act) |-> syncLen == syncExp)
    else $error("tx sync pulse length wrong");
  a_data_edge:
    assert property (txIc && $changed(txDataOut) |-> txClkOut == !txCtl[2])
    else $error("tx data moved on sample edge");
  a_sync_edge:
    assert property (txIs && $changed(txSyncOut) |-> txClkOut == !txCtl[2])
    else $error("tx sync moved on sample edge");
  a_apb_error:
    assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error wrong");
endmodule // spfs_properties

bind spfs_serial_port spfs_properties chk_u (
  .clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pslverr(pslverr),
  .txClkOut(txClkOut), .txClkOe(txClkOe), .txSyncOut(txSyncOut),
  .txSyncOe(txSyncOe), .txDataOut(txDataOut), .rxClkOe(rxClkOe),
  .rxSyncOe(rxSyncOe)
);

// ===== tb/tb_top.sv
// Bench: register table, framed transmit early and late, framed receive.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic        er;
  } spfs_row_t;

  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  paddr = 8'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        txClkOut, txClkOe, txSyncOut, txSyncOe, txDataOut, txDataOe;
  logic        rxClkIn, rxClkOut, rxClkOe, rxSyncIn, rxSyncOut, rxSyncOe;
  logic        rxDataIn;
  logic [31:0] rd;
  logic        err;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          sc;
  // Reads carry the expected value in d, writes the data
  spfs_row_t   rows[12] = '{
    '{1'h0, spfs_pkg::TX_CTL_ADDR, spfs_pkg::CTL_RESET, 1'h0},
    '{1'h0, spfs_pkg::RX_CTL_ADDR, spfs_pkg::CTL_RESET, 1'h0},
    '{1'h0, spfs_pkg::TX_DIV_ADDR, spfs_pkg::DIV_RESET, 1'h0},
    '{1'h0, spfs_pkg::RX_DIV_ADDR, spfs_pkg::DIV_RESET, 1'h0},
    '{1'h0, spfs_pkg::STATUS_ADDR, 32'h0, 1'h0},
    '{1'h0, spfs_pkg::RX_DATA_ADDR, spfs_pkg::DATA_RESET, 1'h0},
    '{1'h0, 8'h1c, 32'h0, 1'h1},
    '{1'h1, 8'h1c, 32'hffffffff, 1'h1},
    '{1'h1, spfs_pkg::TX_CTL_ADDR, 32'hfffee000, 1'h0},
    '{1'h0, spfs_pkg::TX_CTL_ADDR, 32'h0, 1'h0},
    '{1'h1, spfs_pkg::TX_DIV_ADDR, 32'h000f0003, 1'h0},
    '{1'h0, spfs_pkg::TX_DIV_ADDR, 32'h000f0003, 1'h0}};

  spfs_serial_port dut_u (
    .clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txClkIn(rxClkIn),
    .txClkOut(txClkOut), .txClkOe(txClkOe), .txSyncIn(rxSyncIn),
    .txSyncOut(txSyncOut), .txSyncOe(txSyncOe), .txDataOut(txDataOut),
    .txDataOe(txDataOe), .rxClkIn(rxClkIn), .rxClkOut(rxClkOut),
    .rxClkOe(rxClkOe), .rxSyncIn(rxSyncIn), .rxSyncOut(rxSyncOut),
    .rxSyncOe(rxSyncOe), .rxDataIn(rxDataIn));

  spfs_far_side far_u (
    .rxClkIn(rxClkIn), .rxSyncIn(rxSyncIn), .rxDataIn(rxDataIn),
    .txClkOut(txClkOut), .txSyncOut(txSyncOut), .txDataOut(txDataOut));

  always #12.5 clk = ~clk;

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      end_sim;
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk($sformatf("reg%0d", i), rd, rows[i].d);
      chk($sformatf("err%0d", i), {31'h0, err}, {31'h0, rows[i].er});
    end
    // Transmit, internal clock and sync, early then late framing
    for (int m = 0; m < 2; m++)
    begin
      far_u.late = m[0];
      far_u.done = 1'h0;
      apb(1'h1, spfs_pkg::TX_CTL_ADDR, 32'h0);
      apb(1'h1, spfs_pkg::TX_CTL_ADDR, m ? 32'h75f : 32'h71f);
      chk("txOe", {29'h0, txClkOe, txSyncOe, txDataOe}, 32'h7);
      apb(1'h1, spfs_pkg::TX_DATA_ADDR, 32'h1a5 ^ m);
      for (int k = 0; k < 3000 && far_u.done !== 1'h1; k++)
        @(posedge clk);
      chk("txWord", far_u.word, 32'ha5 ^ m);
    end
    // Buffer now empty: two sync periods must pass with no sync
    sc = far_u.syncs;
    repeat (256) @(posedge clk);
    chk("syncs", far_u.syncs, sc);
    // Data-independent: no sync before first write, stale resend flagged
    apb(1'h1, spfs_pkg::TX_CTL_ADDR, 32'h0);
    apb(1'h1, spfs_pkg::TX_CTL_ADDR, 32'h79f);
    far_u.late = 1'h0;
    far_u.done = 1'h0;
    sc = far_u.syncs;
    repeat (256) @(posedge clk);
    chk("diSyncs", far_u.syncs, sc);
    apb(1'h1, spfs_pkg::TX_DATA_ADDR, 32'h3c3);
    for (int k = 0; k < 3000 && far_u.done !== 1'h1; k++)
      @(posedge clk);
    chk("diWord", far_u.word, 32'hc3);
    repeat (200) @(posedge clk);
    apb(1'h0, spfs_pkg::TX_CTL_ADDR, 32'h0);
    chk("stale", rd, 32'h0001079f);
    // Reset in mid-run stops the running transmitter
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    chk("rstOe", {30'h0, txClkOe, txSyncOe}, 32'h0);
    apb(1'h0, spfs_pkg::TX_CTL_ADDR, 32'h0);
    chk("rstCtl", rd, spfs_pkg::CTL_RESET);
    // Receive on external clock and sync; divisors left meaningless
    apb(1'h1, spfs_pkg::RX_DIV_ADDR, 32'h0);
    apb(1'h1, spfs_pkg::RX_CTL_ADDR, 32'h40d);
    chk("rxOe", {28'h0, rxClkOe, rxSyncOe, rxClkOut, rxSyncOut},
        32'h0);
    for (int m = 0; m < 2; m++)
    begin
      far_u.send(m ? 32'h09 : 32'hf6, 5);
      for (int k = 0; k < 40; k++)
      begin
        apb(1'h0, spfs_pkg::STATUS_ADDR, 32'h0);
        if (rd[spfs_pkg::STAT_RX_FULL] === 1'h1)
          break;
      end
      apb(1'h0, spfs_pkg::RX_DATA_ADDR, 32'h0);
      chk("rxWord", rd, m ? 32'h09 : 32'h16);
    end
    end_sim;
  end
endmodule // tb_top
